// >>> rtl/awm_window_mapper.sv
/*
 * A24 window mapper: the 16-bit window register at configuration offset
 * 0xE and the forward decision for A24 cycles seen on the local
 * backplane (outward) and the remote cable bus (inward).
 * assumes synchronous config strobes on sys_clk, a hard and a soft reset
 * request from the device's reset logic, and a decoder-hit input from
 * the device's own A24/A32 decoder for each side.
 * the forward outputs are combinational so a candidate cycle is steered
 * in the same clock; the window register, span and read data are flops.
 * only the standard register layout is modelled.
 */
// Summary of operation
// - window register at offset 0xE, 16-bit and 8-bit access
// - bit 15 reads zero, writes ignored
// - bits 12 and 11 read back as binary 11 whenever the upper byte is read
// - enable bit one forwards matches; zero forwards nothing either way
// - direction one: range applies inward; zero: range applies outward
// - addresses outside the range forward in the opposite direction
// - size field picks how many top base bits are compared
// - range spans 65536 times two to the eight minus size
// - base field compared with address lines 23 to 16
// - hard reset clears enable and direction; soft reset keeps them
// - hard reset clears size and base; soft reset keeps them
// - new setting applies only once the low byte is written
// - own decoder wins; device answers own A24 cycles from both buses
// - compatibility mode uses another layout; avoid with multiframe manager
`timescale 1ns/1ns
module awm_window_mapper (
    input  wire logic        sys_clk,
    input  wire logic        rst_b,
    input  wire logic        hardReset,
    input  wire logic        softReset,
    input  wire logic        cfgSel,
    input  wire logic [5:0]  cfgAddr,
    input  wire logic        cfgWrite,
    input  wire logic [1:0]  cfgByteEn,
    input  wire logic [15:0] cfgWrData,
    output logic [15:0]      cfgRdData,
    output logic             cfgHit,
    input  wire logic        outValid,
    input  wire logic [23:0] outAddr,
    input  wire logic        outOwnHit,
    input  wire logic        inValid,
    input  wire logic [23:0] inAddr,
    input  wire logic        inOwnHit,
    output logic             outForward,
    output logic             inForward,
    output logic             outLocal,
    output logic             inLocal,
    output logic             windowEnable,
    output logic [31:0]      windowSpan
);
    // staged upper byte and the live setting
    logic       hiEn_r,   hiEn_nxt;
    logic       hiDir_r,  hiDir_nxt;
    logic [2:0] hiSize_r, hiSize_nxt;
    logic       en_r,     en_nxt;
    logic       dir_r,    dir_nxt;
    logic [2:0] size_r,   size_nxt;
    logic [7:0] base_r,   base_nxt;
    logic [31:0] span_r,  span_nxt;
    logic [15:0] rd_r,    rd_nxt;
    logic       wrHit;
    logic       outIn;
    logic       inIn;
    logic [15:0] regView;

    // accesses are taken on the rising edge with cfgSel high
    // offset decode
    assign wrHit  = cfgSel && cfgWrite && (cfgAddr == awm_pkg::WIN_OFFSET);
    assign cfgHit = cfgSel && (cfgAddr == awm_pkg::WIN_OFFSET);

    // register state next values
    always_comb begin
        hiEn_nxt   = hiEn_r;
        hiDir_nxt  = hiDir_r;
        hiSize_nxt = hiSize_r;
        en_nxt     = en_r;
        dir_nxt    = dir_r;
        size_nxt   = size_r;
        base_nxt   = base_r;
        if (wrHit && cfgByteEn[1]) begin
            // bit 15 write dropped, bits 12:11 dropped
            hiEn_nxt   = cfgWrData[awm_pkg::EN_BIT];
            hiDir_nxt  = cfgWrData[awm_pkg::DIR_BIT];
            hiSize_nxt = cfgWrData[awm_pkg::SIZE_HI:awm_pkg::SIZE_LO];
        end
        if (wrHit && cfgByteEn[0]) begin
            en_nxt   = hiEn_nxt;
            dir_nxt  = hiDir_nxt;
            size_nxt = hiSize_nxt;
            base_nxt = cfgWrData[awm_pkg::BASE_HI:awm_pkg::BASE_LO];
        end
        // softReset is left unread on purpose: a soft reset keeps every
        // field, so only hardReset or rst_b ever clears the window
        // hard reset beats a write in the same cycle and drops the staged byte
        // hard reset clears; soft reset leaves all alone
        if (hardReset) begin
            hiEn_nxt   = awm_pkg::EN_RST;
            hiDir_nxt  = awm_pkg::DIR_RST;
            hiSize_nxt = awm_pkg::SIZE_RST;
            en_nxt     = awm_pkg::EN_RST;
            dir_nxt    = awm_pkg::DIR_RST;
            size_nxt   = awm_pkg::SIZE_RST;
            base_nxt   = awm_pkg::BASE_RST;
        end
    end

    // register state flops
    // rst_b clears like a hard reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hiEn_r   <= awm_pkg::EN_RST;
            hiDir_r  <= awm_pkg::DIR_RST;
            hiSize_r <= awm_pkg::SIZE_RST;
            en_r     <= awm_pkg::EN_RST;
            dir_r    <= awm_pkg::DIR_RST;
            size_r   <= awm_pkg::SIZE_RST;
            base_r   <= awm_pkg::BASE_RST;
        end else begin
            hiEn_r   <= hiEn_nxt;
            hiDir_r  <= hiDir_nxt;
            hiSize_r <= hiSize_nxt;
            en_r     <= en_nxt;
            dir_r    <= dir_nxt;
            size_r   <= size_nxt;
            base_r   <= base_nxt;
        end
    end

    // standard layout only; the alternate layout picked by the
    // compatibility mode bit is not carried here, so software must keep
    // that bit clear whenever a multiframe manager is in use
    // read view; upper byte shows staged value so a byte read-back matches
    // fixed reserved bits
    assign regView = {awm_pkg::RSVD0_VAL, hiEn_r, hiDir_r, awm_pkg::ONES_VAL, hiSize_r, base_r};

    // read data, registered, one cycle after the select
    // other offsets leave the last read data standing
    always_comb begin
        rd_nxt = rd_r;
        if (cfgHit && !cfgWrite) begin
            rd_nxt = 16'h0000;
            if (cfgByteEn[1]) begin
                rd_nxt[15:8] = regView[15:8];
            end
            if (cfgByteEn[0]) begin
                rd_nxt[7:0] = regView[7:0];
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            rd_r <= 16'h0000;
        end else begin
            rd_r <= rd_nxt;
        end
    end

    // lanes not selected read zero; the value stands until the next read
    assign cfgRdData = rd_r;

    // one comparator per side
    awm_range_match u_matchOut (
        .size     (size_r),
        .base     (base_r),
        .addr     (outAddr),
        .isInside (outIn)
    );

    // both sides share the live size and base; each compares its own address
    awm_range_match u_matchIn (
        .size     (size_r),
        .base     (base_r),
        .addr     (inAddr),
        .isInside (inIn)
    );

    // forward decision, combinational so a cycle is steered at once
    always_comb begin
        // a decoder hit is answered locally and never forwarded
        // own decoder first
        outLocal = outValid && outOwnHit;
        inLocal  = inValid && inOwnHit;
        outForward = 1'b0;
        inForward  = 1'b0;
        if (en_r) begin
            // range one way, complement the other
            if (dir_r == awm_pkg::AWM_DIR_IN) begin
                inForward  = inValid && !inOwnHit && inIn;
                outForward = outValid && !outOwnHit && !outIn;
            end else begin
                outForward = outValid && !outOwnHit && outIn;
                inForward  = inValid && !inOwnHit && !inIn;
            end
        end
    end

    // span from the next size, so the flop moves in step with the live
    // fields and the output comes straight from a register
    // window span in addresses
    always_comb begin
        span_nxt = 32'h0001_0000 << (4'h8 - {1'b0, size_nxt});
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            span_r <= 32'h0001_0000 << (4'h8 - {1'b0, awm_pkg::SIZE_RST});
        end else begin
            span_r <= span_nxt;
        end
    end

    assign windowSpan   = span_r;
    assign windowEnable = en_r;
endmodule

// >>> rtl/awm_pkg.sv
/*
 * package for the A24 window mapper: register offset, field layout,
 * reset values and access widths.
 * assumes nothing of its surroundings; every use is awm_pkg::name.
 */
package awm_pkg;
    // configuration offset of the window register (byte address)
    localparam logic [5:0]  WIN_OFFSET    = 6'h0E;
    localparam int          REG_W         = 16;
    // field positions
    localparam int          RSVD0_BIT     = 15;
    localparam int          EN_BIT        = 14;
    localparam int          DIR_BIT       = 13;
    localparam int          ONES_HI       = 12;
    localparam int          ONES_LO       = 11;
    localparam int          SIZE_HI       = 10;
    localparam int          SIZE_LO       = 8;
    localparam int          BASE_HI       = 7;
    localparam int          BASE_LO       = 0;
    localparam int          SIZE_W        = 3;
    localparam int          BASE_W        = 8;
    localparam int          ADDR_W        = 24;
    // address lines compared against the base field
    localparam int          CMP_HI        = 23;
    localparam int          CMP_LO        = 16;
    // reset values after a hard reset
    localparam logic        EN_RST        = 1'b0;
    localparam logic        DIR_RST       = 1'b0;
    localparam logic [2:0]  SIZE_RST      = 3'h0;
    localparam logic [7:0]  BASE_RST      = 8'h00;
    // fixed read-back of the reserved bits
    localparam logic        RSVD0_VAL     = 1'b0;
    localparam logic [1:0]  ONES_VAL      = 2'h3;
    // forward direction codes
    typedef enum logic {
        AWM_DIR_OUT,
        AWM_DIR_IN
    } awm_dir_e;
endpackage

// >>> rtl/awm_range_match.sv
/*
 * one window comparator: top size bits of base against address 23:16.
 * assumes a combinational use; the caller registers nothing through it.
 */
`timescale 1ns/1ns
module awm_range_match (
    input  wire logic [2:0]  size,
    input  wire logic [7:0]  base,
    input  wire logic [23:0] addr,
    output logic             isInside
);
    logic [7:0] mask;

    // mask with size leading ones, compared bits only
    always_comb begin
        mask   = 8'hFF << (4'h8 - {1'b0, size});
        if (size == 3'h0) begin
            mask = 8'h00;
        end
        isInside = ((addr[awm_pkg::CMP_HI:awm_pkg::CMP_LO] ^ base) & mask) == 8'h00;
    end
endmodule

// >>> verif/awm_window_mapper_chk.sv
/* port checker for the A24 window mapper.
   assumes a bind onto awm_window_mapper, all names alike. */
`timescale 1ns/1ns
module awm_window_mapper_chk (
    input wire logic        sys_clk,
    input wire logic        rst_b,
    input wire logic        hardReset,
    input wire logic        cfgSel,
    input wire logic        cfgWrite,
    input wire logic        cfgHit,
    input wire logic        outValid,
    input wire logic        outOwnHit,
    input wire logic        inValid,
    input wire logic        inOwnHit,
    input wire logic        outForward,
    input wire logic        inForward,
    input wire logic        windowEnable,
    input wire logic [5:0]  cfgAddr,
    input wire logic [1:0]  cfgByteEn,
    input wire logic [15:0] cfgWrData,
    input wire logic [15:0] cfgRdData,
    input wire logic [23:0] outAddr,
    input wire logic [23:0] inAddr,
    input wire logic [31:0] windowSpan
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_b);
    // accepted register accesses; hard reset beats a write
    sequence sRd; cfgHit && !cfgWrite; endsequence
    sequence sWr(be); cfgHit && cfgWrite && cfgByteEn == be && !hardReset; endsequence
    sequence sSame; outValid && inValid && outAddr == inAddr && !outOwnHit && !inOwnHit; endsequence
    property pTwoWays; windowEnable ##0 sSame |-> outForward != inForward; endproperty
    a_hit_decode: assert property (cfgHit == (cfgSel && cfgAddr == 6'h0E))
        else $error("hit decode");
    a_rsvd_zero: assert property (sRd |=> !cfgRdData[15])
        else $error("bit 15 set");
    a_ones_read: assert property (sRd ##0 cfgByteEn[1] |=> cfgRdData[12:11] == 2'h3)
        else $error("bits 12:11");
    a_enable_gate: assert property (!windowEnable |-> !outForward && !inForward)
        else $error("forward while off");
    a_full_commit: assert property (sWr(2'h3) |=> windowEnable == $past(cfgWrData[14]))
        else $error("enable not taken");
    a_upper_hold: assert property (sWr(2'h2) |=> $stable(windowEnable))
        else $error("upper byte enabled");
    a_two_ways: assert property (pTwoWays)
        else $error("both or neither way");
    a_span_pow: assert property ($onehot(windowSpan) && windowSpan >= 32'h10000)
        else $error("span shape");
    a_hard_clear: assert property (hardReset |=> !windowEnable && windowSpan == 32'h1000000)
        else $error("hard reset");
    a_own_first: assert property (outOwnHit || inOwnHit |-> !(outOwnHit && outForward) && !(inOwnHit && inForward))
        else $error("own hit forwarded");
endmodule

// >>> verif/awm_far_masters.sv
/* far-side masters: A24 candidate cycles on both buses.
   assumes the bench hands a top-byte hint near the window. */
`timescale 1ns/1ns
module awm_far_masters (
    input  wire logic        sys_clk,
    input  wire logic [7:0]  hintTop,
    output logic             outValid,
    output logic             outOwnHit,
    output logic             inValid,
    output logic             inOwnHit,
    output logic [23:0]      outAddr,
    output logic [23:0]      inAddr
);
    int          seed = 78002;
    int          r;
    logic [23:0] a;
    // one driver per output; unknown until the first falling edge, inside reset
    // new cycle each falling edge; half aimed near the window
    always @(negedge sys_clk) begin
        r = $random(seed);
        a = {r[6] ? hintTop : r[15:8], r[31:16]};
        outValid <= r[0];
        outOwnHit <= r[0] & r[1] & r[2];
        inValid <= r[3];
        inOwnHit <= r[3] & r[4] & r[5];
        outAddr <= a;
        inAddr <= r[7] ? a : a ^ 24'($random(seed));
    end
endmodule

// >>> verif/awm_window_mapper_test.sv
/* self-checking bench for the A24 window mapper.
   assumes the far-side masters model and the port checker. */
`timescale 1ns/1ns
module awm_window_mapper_test;
    logic        sys_clk = 1'b0, rst_b = 1'b0, hardReset = 1'b0, softReset = 1'b0, cfgSel = 1'b0, cfgWrite = 1'b0;
    logic [5:0]  cfgAddr = 6'h0E;
    logic [1:0]  cfgByteEn = 2'h3;
    logic [15:0] cfgWrData = 16'h0000, cfgRdData, rdQ[$];
    logic        outValid, outOwnHit, inValid, inOwnHit, outForward, inForward, outLocal, inLocal, windowEnable, cfgHit;
    logic [23:0] outAddr, inAddr;
    logic [31:0] windowSpan;
    // bench copy of staged upper byte and live fields
    logic [7:0]  hiS = 8'h00, bs = 8'h00;
    logic [2:0]  sz = 3'h0;
    logic        en = 1'b0, dir = 1'b0, lastRd = 1'b0;
    int          n_errors = 0, comparisons = 0, cyc = 0;
    awm_window_mapper u_dut (.*);
    awm_far_masters u_far (.hintTop(bs), .*);
    initial forever #2 sys_clk = ~sys_clk;
    task automatic chk(input logic [63:0] e, input logic [63:0] g);
        comparisons++;
        if (e !== g) begin
            n_errors++;
            $display("CHECK FAILED t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic complete_run();
        if (n_errors == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // one access; read notes its answer, write updates the copy
    task automatic acc(input logic w, input logic [1:0] be, input logic [5:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        {cfgSel, cfgWrite, cfgByteEn, cfgAddr, cfgWrData} = {1'b1, w, be, a, d};
        if (!w && a == 6'h0E) rdQ.push_back({be[1] ? {1'b0, hiS[6:5], 2'h3, hiS[2:0]} : 8'h00, be[0] ? bs : 8'h00});
        @(negedge sys_clk);
        cfgSel = 1'b0;
        if (w && a == 6'h0E && be[1]) hiS = d[15:8];
        if (w && a == 6'h0E && be[0]) {en, dir, sz, bs} = {hiS[6:5], hiS[2:0], d[7:0]};
    endtask
    function automatic logic ins(input logic [23:0] a);
        return sz == 3'h0 || ((a[23:16] ^ bs) >> (4'h8 - sz)) == 8'h00;
    endfunction
    // forward decision and span against the copy, every cycle
    task automatic run(input int n);
        repeat (n) begin
            @(posedge sys_clk);
            chk({outValid & en & ~outOwnHit & (ins(outAddr) ^ dir), inValid & en & ~inOwnHit & (ins(inAddr) ~^ dir),
                outValid & outOwnHit, inValid & inOwnHit, en, 32'h10000 << (8 - sz)},
                {outForward, inForward, outLocal, inLocal, windowEnable, windowSpan});
        end
    endtask
    // read data lands at the take edge; it is checked at the next falling edge
    always @(posedge sys_clk) lastRd <= cfgSel && !cfgWrite && cfgAddr == 6'h0E;
    always @(negedge sys_clk) if (lastRd) chk(rdQ.pop_front(), cfgRdData);
    // hang guard: a few thousand cycles is ample
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 4000) begin
            n_errors++;
            complete_run();
        end
    end
    initial begin
        repeat (20) @(negedge sys_clk);
        rst_b = 1'b1;
        acc(1'b0, 2'h3, 6'h0E, 16'h0000);
        for (int k = 0; k < 16; k++) begin
            acc(1'b1, 2'h2, 6'h0E, {2'h3, k[0], k[1], ~k[0], 3'(k >> 1), 8'h00});
            run(4);
            acc(1'b1, 2'h1, 6'h0E, {8'hFF, 8'(k * 29)});
            acc(1'b0, 2'h3, 6'h0E, 16'h0000);
            run(30);
        end
        acc(1'b1, 2'h3, 6'h0E, 16'h2312);
        run(20);
        acc(1'b1, 2'h3, 6'h0C, 16'h7FFF);
        acc(1'b0, 2'h1, 6'h0C, 16'h0000);
        acc(1'b0, 2'h2, 6'h0E, 16'h0000);
        acc(1'b1, 2'h3, 6'h0E, 16'h4500);
        @(negedge sys_clk) softReset = 1'b1;
        @(negedge sys_clk) softReset = 1'b0;
        acc(1'b0, 2'h3, 6'h0E, 16'h0000);
        run(10);
        @(negedge sys_clk) hardReset = 1'b1;
        @(negedge sys_clk) hardReset = 1'b0;
        {hiS, en, dir, sz, bs} = '0;
        acc(1'b0, 2'h3, 6'h0E, 16'h0000);
        run(10);
        complete_run();
    end
endmodule
bind awm_window_mapper awm_window_mapper_chk u_chk (.*);
